// File: hw/dtb_buffer.sv
// Double transmit message buffer with host part, controller part, swap and copy-back
`timescale 1ns/1ps
`default_nettype none
`include "dtb_map.svh"

module dtb_buffer
   import dtb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Transmit engine
   input wire logic tx_start_i,
   input wire logic tx_done_i,
   input wire logic tx_null_i,
   input wire logic [4:0] tx_rd_idx_i,
   input wire logic [15:0] tx_ssv_i,
   input wire logic tx_ssv_we_i,
   output logic tx_locked_o,
   output logic [31:0] tx_data_o,
   output logic [31:0] tx_hdr_o,
   output logic tx_ready_o
);

   // ***********************
   // Storage
   // ***********************
   // Two physical halves; side_q selects which one is the controller part
   logic [31:0] mem_q [2][`DTB_DATA_WORDS];
   logic [31:0] hdr_q [2];
   logic [15:0] ssv_q [2];
   dtb_csr_t csr_q [2];
   logic side_q;
   logic [5:0] bufnum_q;
   dtb_copy_state_t cp_state_q;
   logic [5:0] cp_idx_q;
   dtb_tx_state_t tx_state_q;
   dtb_tx_req_t req;
   logic hp;
   logic cp;

   assign cp = side_q;
   assign hp = ~side_q;
   assign req = '{start: tx_start_i, done: tx_done_i, null_frame: tx_null_i,
                  rd_idx: tx_rd_idx_i};

   // ***********************
   // Bus decode
   // ***********************
   logic acc;
   logic wr;
   logic hit_ctrl;
   logic hit_hcsr;
   logic hit_ccsr;
   logic hit_hdr;
   logic hit_ssv;
   logic hit_cchdr;
   logic hit_data;
   logic mapped;
   logic busy;
   logic configured;
   logic lock_write;
   logic lock_grant;
   logic unlock_commit;
   logic host_wr_ok;
   logic [4:0] widx;

   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr = acc & wb_we_i;
   // Host word 0 at the payload base is engine word 0
   assign widx = {1'b0, wb_adr_i[5:2]};
   always_comb begin
      hit_ctrl = 1'b0;
      hit_hcsr = 1'b0;
      hit_ccsr = 1'b0;
      hit_hdr = 1'b0;
      hit_ssv = 1'b0;
      hit_cchdr = 1'b0;
      hit_data = 1'b0;
      if (wb_adr_i == `DTB_OFS_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (wb_adr_i == `DTB_OFS_HCSR) begin
         hit_hcsr = 1'b1;
      end else if (wb_adr_i == `DTB_OFS_CCSR) begin
         hit_ccsr = 1'b1;
      end else if (wb_adr_i == `DTB_OFS_HDR) begin
         hit_hdr = 1'b1;
      end else if (wb_adr_i == `DTB_OFS_SSV) begin
         hit_ssv = 1'b1;
      end else if (wb_adr_i == `DTB_OFS_CCHDR) begin
         hit_cchdr = 1'b1;
      end else if (wb_adr_i[7:6] == 2'b01 && wb_adr_i[1:0] == 2'b00) begin
         hit_data = 1'b1;
      end
   end
   assign mapped = hit_ctrl | hit_hcsr | hit_ccsr | hit_hdr | hit_ssv | hit_cchdr | hit_data;

   assign busy = (cp_state_q != DTB_IDLE);
   // Frame identifier zero means not configured
   assign configured = (hdr_q[hp][`DTB_H_FID_LSB +: 11] != 11'h000);
   assign lock_write = wr & hit_hcsr & wb_sel_i[0] & wb_dat_i[`DTB_B_LOCK];
   // Lock refused during copy or while controller part still committed
   assign lock_grant = lock_write & ~csr_q[hp].lock & ~busy
                       & ~csr_q[cp].cmt;
   assign unlock_commit = lock_write & csr_q[hp].lock & csr_q[hp].cmt & configured;
   // Content writes only while the host holds the lock
   assign host_wr_ok = wr & csr_q[hp].lock;

   // ***********************
   // Wishbone answer
   // ***********************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= acc & mapped;
         wb_err_o <= acc & ~mapped;
      end
   end

   // Host reads the host part at fixed offsets, except CCSR and CCHDR, which show the controller part
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (acc) begin
         wb_dat_o <= 32'h0000_0000;
         if (hit_ctrl) begin
            wb_dat_o <= {26'h000_0000, bufnum_q};
         end else if (hit_hcsr) begin
            wb_dat_o <= {24'h00_0000, csr_q[hp]};
         end else if (hit_ccsr) begin
            wb_dat_o <= {24'h00_0000, csr_q[cp]};
         end else if (hit_hdr) begin
            wb_dat_o <= hdr_q[hp];
         end else if (hit_ssv) begin
            wb_dat_o <= {16'h0000, ssv_q[hp]};
         end else if (hit_cchdr) begin
            wb_dat_o <= hdr_q[cp];
         end else if (hit_data) begin
            wb_dat_o <= mem_q[hp][widx];
         end
      end
   end

   // ***********************
   // Configuration
   // ***********************
   // Controller part number fixed outside reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bufnum_q <= `DTB_BUFNUM_RESET;
      end
   end

   // ***********************
   // Swap and copy-back
   // ***********************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         side_q <= 1'b0;
      end else if (unlock_commit && !busy) begin
         side_q <= ~side_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cp_state_q <= DTB_IDLE;
         cp_idx_q <= 6'h00;
      end else begin
         case (cp_state_q)
            DTB_IDLE: begin
               if (unlock_commit) begin
                  cp_state_q <= DTB_COPY;
                  cp_idx_q <= 6'h00;
               end
            end
            DTB_COPY: begin
               cp_idx_q <= cp_idx_q + 6'h01;
               if (cp_idx_q == 6'(`DTB_DATA_WORDS - 1)) begin
                  cp_state_q <= DTB_IDLE;
               end
            end
            default: cp_state_q <= DTB_IDLE;
         endcase
      end
   end

   // Payload: host writes to host part, copy-back fills host part from controller part
   always_ff @(posedge clk_i) begin
      if (busy) begin
         mem_q[hp][cp_idx_q[4:0]] <= mem_q[cp][cp_idx_q[4:0]];
      end else if (host_wr_ok && hit_data) begin
         for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
               mem_q[hp][widx][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // Header: copied as a whole in the first copy-back cycle, one cycle after the swap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hdr_q[0] <= 32'h0000_0000;
         hdr_q[1] <= 32'h0000_0000;
      end else if (busy && cp_idx_q == 6'h00) begin
         hdr_q[hp] <= hdr_q[cp];
      end else if (!busy && host_wr_ok && hit_hdr && wb_sel_i == 4'hF) begin
         hdr_q[hp] <= wb_dat_i;
      end
   end

   // Slot status: engine updates both halves, copy-back refreshes host part
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ssv_q[0] <= 16'h0000;
         ssv_q[1] <= 16'h0000;
      end else if (tx_ssv_we_i && !req.null_frame && csr_q[cp].cc_lock) begin
         ssv_q[0] <= tx_ssv_i;
         ssv_q[1] <= tx_ssv_i;
      end else if (busy && cp_idx_q == 6'h00) begin
         ssv_q[hp] <= ssv_q[cp];
      end
   end

   // ***********************
   // Control and status
   // ***********************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         csr_q[0] <= dtb_csr_t'(`DTB_CSR_RESET);
         csr_q[1] <= dtb_csr_t'(`DTB_CSR_RESET);
      end else begin
         if (unlock_commit && !busy) begin
            // Committed host half becomes controller part; event cleared, valid set
            csr_q[hp] <= '{cc_lock: 1'b0, busy: 1'b0, bt: csr_q[hp].bt, tt: csr_q[hp].tt,
                           evt: 1'b0, valid: 1'b1, cmt: 1'b1, lock: 1'b0};
            // Former controller half becomes host part, commit shown until copy ends
            csr_q[cp] <= '{cc_lock: 1'b0, busy: 1'b1, bt: csr_q[hp].bt, tt: csr_q[hp].tt,
                           evt: 1'b0, valid: 1'b0, cmt: 1'b1, lock: 1'b0};
         end else begin
            if (busy && cp_idx_q == 6'(`DTB_DATA_WORDS - 1)) begin
               csr_q[hp].cmt <= 1'b0;
               csr_q[hp].busy <= 1'b0;
            end
            // Identifier is written under lock, so it gates commit, not lock
            if (lock_grant) begin
               csr_q[hp].lock <= 1'b1;
            end else if (lock_write && csr_q[hp].lock) begin
               csr_q[hp].lock <= 1'b0;
            end
            if (wr && hit_hcsr && wb_sel_i[0] && csr_q[hp].lock) begin
               csr_q[hp].cmt <= wb_dat_i[`DTB_B_CMT];
               csr_q[hp].tt <= wb_dat_i[`DTB_B_TT];
               csr_q[hp].bt <= wb_dat_i[`DTB_B_BT];
               csr_q[cp].bt <= wb_dat_i[`DTB_B_BT];
            end
            // Null frames change no status bits
            if (tx_state_q == DTB_TX_LOCKREQ && !req.null_frame) begin
               csr_q[cp].cc_lock <= 1'b1;
            end
            if (tx_state_q == DTB_TX_SEND && req.done && !req.null_frame) begin
               csr_q[cp].cc_lock <= 1'b0;
               csr_q[cp].cmt <= 1'b0;
               csr_q[cp].evt <= 1'b1;
               csr_q[cp].valid <= csr_q[cp].tt;
            end
         end
      end
   end

   // ***********************
   // Transmit side
   // ***********************
   // Runs independently of host accesses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_state_q <= DTB_TX_IDLE;
      end else begin
         case (tx_state_q)
            DTB_TX_IDLE: begin
               if (req.start && csr_q[cp].valid && hdr_q[cp][10:0] != 11'h000) begin
                  tx_state_q <= DTB_TX_LOCKREQ;
               end
            end
            DTB_TX_LOCKREQ: begin
               tx_state_q <= req.null_frame ? DTB_TX_IDLE : DTB_TX_SEND;
            end
            DTB_TX_SEND: begin
               if (req.done) begin
                  tx_state_q <= DTB_TX_IDLE;
               end
            end
            default: tx_state_q <= DTB_TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_locked_o <= 1'b0;
         tx_ready_o <= 1'b0;
         tx_data_o <= 32'h0000_0000;
         tx_hdr_o <= 32'h0000_0000;
      end else begin
         tx_locked_o <= csr_q[cp].cc_lock;
         tx_ready_o <= csr_q[cp].valid & csr_q[cp].cmt;
         tx_data_o <= mem_q[cp][req.rd_idx];
         tx_hdr_o <= hdr_q[cp];
      end
   end

endmodule : dtb_buffer
`default_nettype wire

// File: hw/dtb_map.svh
// Register offsets, field positions, sizes and reset values of the double transmit buffer
`ifndef DTB_MAP_SVH
`define DTB_MAP_SVH

// Register word offsets (byte addresses)
`define DTB_OFS_CTRL 8'h00
`define DTB_OFS_HCSR 8'h04
`define DTB_OFS_CCSR 8'h08
`define DTB_OFS_HDR 8'h0C
`define DTB_OFS_SSV 8'h10
`define DTB_OFS_CCHDR 8'h14
`define DTB_OFS_DATA 8'h40

// Buffer control/status register fields
`define DTB_B_LOCK 0
`define DTB_B_CMT 1
`define DTB_B_VALID 2
`define DTB_B_EVT 3
`define DTB_B_TT 4
`define DTB_B_BT 5
`define DTB_B_BUSY 6
`define DTB_B_CCLOCK 7

// Header fields
`define DTB_H_FID_LSB 0
`define DTB_H_LEN_LSB 11
`define DTB_H_CRC_LSB 18
`define DTB_H_PP 29
`define DTB_H_RSV 30

// Control register fields
`define DTB_C_BUFNUM_LSB 0

// Sizes and reset values
`define DTB_DATA_WORDS 32
`define DTB_CSR_RESET 8'h00
`define DTB_BUFNUM_RESET 6'h02

`endif

// File: hw/dtb_pkg.sv
// Types shared by the double transmit buffer
package dtb_pkg;
   typedef enum logic [1:0] {
      DTB_IDLE,
      DTB_COPY
   } dtb_copy_state_t;

   typedef enum logic [1:0] {
      DTB_TX_IDLE,
      DTB_TX_LOCKREQ,
      DTB_TX_SEND
   } dtb_tx_state_t;

   typedef struct packed {
      logic cc_lock;
      logic busy;
      logic bt;
      logic tt;
      logic evt;
      logic valid;
      logic cmt;
      logic lock;
   } dtb_csr_t;

   typedef struct packed {
      logic start;
      logic done;
      logic null_frame;
      logic [4:0] rd_idx;
   } dtb_tx_req_t;
endpackage : dtb_pkg

// File: test/dtb_chk.sv
// Port checks of the double transmit buffer
`timescale 1ns/1ps
`default_nettype none
module dtb_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic tx_start_i,
   input wire logic tx_done_i,
   input wire logic tx_null_i,
   input wire logic tx_locked_o,
   input wire logic tx_ready_o,
   input wire logic [31:0] tx_hdr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
   endproperty
   a_ack: assert property (p_ack) else $error("late bus answer");
   property p_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ack too long");
   property p_excl;
      !(wb_ack_o && wb_err_o);
   endproperty
   a_excl: assert property (p_excl) else $error("ack with err");
   property p_lock;
      $rose(tx_locked_o) |-> $past(tx_start_i) && $past(tx_ready_o);
   endproperty
   a_lock: assert property (p_lock) else $error("lock without request");
   property p_fid;
      $rose(tx_locked_o) |-> $past(tx_hdr_o[10:0]) != 11'h000;
   endproperty
   a_fid: assert property (p_fid) else $error("lock on empty id");
   property p_null;
      tx_done_i && tx_null_i |=> $stable(tx_ready_o);
   endproperty
   a_null: assert property (p_null) else $error("null frame changed state");
   property p_done;
      tx_done_i && !tx_null_i && tx_locked_o && tx_ready_o |-> ##2 !tx_ready_o;
   endproperty
   a_done: assert property (p_done) else $error("commit kept after send");
   property p_hold;
      tx_locked_o && $past(tx_locked_o) |-> $stable(tx_hdr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("header moved in send");
endmodule : dtb_chk
`default_nettype wire

// File: test/dtb_eng.sv
// Transmit engine model facing the controller part
`timescale 1ns/1ps
`default_nettype none
module dtb_eng (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic null_i,
   input wire logic tx_locked_i,
   output logic tx_start_o,
   output logic tx_done_o,
   output logic [4:0] tx_rd_idx_o,
   output logic tx_ssv_we_o
);
   logic [2:0] st_q;
   // Index changes every cycle, also outside frames
   always_ff @(posedge clk_i) begin
      tx_rd_idx_o <= rst_i ? 5'h00 : tx_rd_idx_o + 5'h01;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= 3'h0;
         tx_start_o <= 1'b0;
         tx_done_o <= 1'b0;
         tx_ssv_we_o <= 1'b0;
      end else begin
         case (st_q)
            3'h0: if (go_i) begin
               tx_start_o <= 1'b1;
               // Null frames need no lock and end at once
               st_q <= null_i ? 3'h3 : 3'h1;
            end
            3'h1: if (tx_locked_i) st_q <= 3'h2;
            3'h2: if (tx_rd_idx_o == 5'h1f) begin
               tx_ssv_we_o <= 1'b1;
               st_q <= 3'h3;
            end
            3'h3: begin
               tx_ssv_we_o <= 1'b0;
               tx_done_o <= 1'b1;
               tx_start_o <= 1'b0;
               st_q <= 3'h4;
            end
            default: begin
               tx_done_o <= 1'b0;
               if (!go_i) st_q <= 3'h0;
            end
         endcase
      end
   end
endmodule : dtb_eng
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the double transmit buffer
`timescale 1ns/1ps
`default_nettype none
`include "dtb_map.svh"
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin mismatches++; \
   $display("ERROR %s exp %h got %h", n, e, s); end end
module testbench import dtb_pkg::*; ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, nul = 1'b0, got_err;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000, hdr, ex, mk;
   logic [31:0] d [16];
   logic [15:0] ssv = 16'h0000;
   logic [31:0] ex_q [$], mk_q [$];
   logic [31:0] wb_dat_o, tx_hdr_o, tx_data_o;
   logic wb_ack_o, wb_err_o, tx_start, tx_done, tx_ssv_we, tx_locked_o, tx_ready_o;
   logic [4:0] tx_rd_idx, ix;
   int mismatches = 0, tests_run = 0, cycles = 0;
   localparam logic [31:0] LK = 32'h1 << `DTB_B_LOCK;
   localparam logic [31:0] CM = 32'h1 << `DTB_B_CMT;
   localparam logic [31:0] VA = 32'h1 << `DTB_B_VALID;
   localparam logic [31:0] EV = 32'h1 << `DTB_B_EVT;
   localparam logic [31:0] TB = (32'h1 << `DTB_B_TT) | (32'h1 << `DTB_B_BT);
   localparam logic [31:0] BB = 32'h1 << `DTB_B_BT;
   always #5 clk_i = ~clk_i;
   dtb_buffer DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_start_i(tx_start), .tx_done_i(tx_done),
      .tx_null_i(nul), .tx_rd_idx_i(tx_rd_idx), .tx_ssv_i(ssv), .tx_ssv_we_i(tx_ssv_we),
      .tx_locked_o(tx_locked_o), .tx_data_o(tx_data_o), .tx_hdr_o(tx_hdr_o),
      .tx_ready_o(tx_ready_o));
   dtb_eng u_eng (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .null_i(nul),
      .tx_locked_i(tx_locked_o),
      .tx_start_o(tx_start), .tx_done_o(tx_done), .tx_rd_idx_o(tx_rd_idx),
      .tx_ssv_we_o(tx_ssv_we));
   task automatic stop_test;
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && !we && ex_q.size() > 0) begin
         ex = ex_q.pop_front();
         mk = mk_q.pop_front();
         `CHK("wb_dat_o", ex, wb_dat_o & mk)
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= v;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
      got_err = wb_err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      ex_q.push_back(e & m);
      mk_q.push_back(m);
      wb(1'b0, a, 32'h0000_0000);
   endtask : rd
   task automatic send(input logic n);
      nul <= n;
      go <= 1'b1;
      for (int i = 0; i < 100 && tx_done !== 1'b1; i++) @(posedge clk_i);
      go <= 1'b0;
      nul <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : send
   initial begin
      void'($urandom(49997));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`DTB_OFS_CTRL, `DTB_BUFNUM_RESET, 32'h0000_003f);
      rd(`DTB_OFS_HCSR, `DTB_CSR_RESET, 32'h0000_00ff);
      rd(`DTB_OFS_CCSR, `DTB_CSR_RESET, 32'h0000_00ff);
      hdr = ($urandom & 32'h7fff_ffff) | 32'h0000_0001;
      wb(1'b1, `DTB_OFS_HDR, hdr);
      rd(`DTB_OFS_HDR, 32'h0000_0000, 32'hffff_ffff);
      wb(1'b1, `DTB_OFS_HCSR, LK | TB);
      rd(`DTB_OFS_HCSR, LK, LK);
      wb(1'b1, `DTB_OFS_HCSR, TB);
      wb(1'b1, `DTB_OFS_HDR, hdr);
      wb(1'b1, `DTB_OFS_CCSR, 32'h0000_00ff);
      rd(`DTB_OFS_CCSR, BB, LK | CM | VA | TB);
      for (int i = 0; i < 16; i++) begin
         d[i] = $urandom;
         wb(1'b1, `DTB_OFS_DATA + 8'(4 * i), d[i]);
      end
      wb(1'b1, `DTB_OFS_HCSR, CM | TB);
      wb(1'b1, `DTB_OFS_HCSR, LK | CM | TB);
      rd(`DTB_OFS_HCSR, CM, LK | CM);
      wb(1'b1, `DTB_OFS_HCSR, LK | TB);
      rd(`DTB_OFS_HCSR, CM, LK | CM);
      rd(`DTB_OFS_CCSR, CM | VA, CM | VA | EV);
      `CHK("tx_hdr_o", hdr, tx_hdr_o)
      repeat (40) @(posedge clk_i);
      do @(posedge clk_i); while (tx_rd_idx >= 5'h10);
      ix = tx_rd_idx;
      @(posedge clk_i);
      `CHK("tx_data_o", d[ix], tx_data_o)
      rd(`DTB_OFS_HDR, hdr, 32'h7fff_ffff);
      for (int i = 0; i < 16; i++) rd(`DTB_OFS_DATA + 8'(4 * i), d[i], 32'hffff_ffff);
      wb(1'b1, `DTB_OFS_DATA, $urandom);
      rd(`DTB_OFS_DATA, d[0], 32'hffff_ffff);
      wb(1'b1, `DTB_OFS_HCSR, LK | TB);
      rd(`DTB_OFS_HCSR, 32'h0000_0000, LK);
      send(1'b1);
      `CHK("tx_ready_o", 1'b1, tx_ready_o)
      ssv <= 16'($urandom);
      send(1'b0);
      `CHK("tx_ready_o", 1'b0, tx_ready_o)
      rd(`DTB_OFS_CCSR, EV | VA, CM | EV | VA);
      rd(`DTB_OFS_SSV, {16'h0000, ssv}, 32'h0000_ffff);
      wb(1'b1, `DTB_OFS_HCSR, LK | TB);
      rd(`DTB_OFS_HCSR, LK, LK);
      wb(1'b1, `DTB_OFS_HDR, hdr & 32'hffff_f800);
      wb(1'b1, `DTB_OFS_HCSR, CM | TB);
      wb(1'b1, `DTB_OFS_HCSR, LK | CM | TB);
      rd(`DTB_OFS_CCSR, EV | VA, CM | EV | VA);
      wb(1'b1, 8'hfc, 32'h0000_0000);
      `CHK("wb_err_o", 1'b1, got_err)
      repeat (4) @(posedge clk_i);
      stop_test();
   end
endmodule : testbench
bind dtb_buffer dtb_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tx_start_i(tx_start_i),
   .tx_done_i(tx_done_i), .tx_null_i(tx_null_i), .tx_locked_o(tx_locked_o),
   .tx_ready_o(tx_ready_o), .tx_hdr_o(tx_hdr_o));
`default_nettype wire
